// ---- bench/ddli_host.sv ----
// host sample source model driving one channel
`timescale 1ns/100ps
module ddli_host
(
    input wire logic clk_sys_in,
    output ddli_pkg::ddli_chan_in_t pins_out
);
    import ddli_pkg::*;
    initial pins_out = '0;
    // strobe and clock tied: clock never follows strobe
    task automatic send(input ddli_word_t w);
        @(posedge clk_sys_in);
        pins_out <= '{input_strobe: 1'b1, update_clock: 1'b1, word: w};
        // 4-cycle levels keep the update rate low
        repeat (4) @(posedge clk_sys_in);
        pins_out.input_strobe <= 1'b0;
        pins_out.update_clock <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        // hold time over: port shows a stale, inverted word
        pins_out.word <= ~w;
    endtask : send
endmodule : ddli_host

// ---- bench/ddli_top_bench.sv ----
// self-checking bench for the dual converter double-latch input block
`timescale 1ns/100ps
module ddli_top_bench;
    import ddli_pkg::*;
    logic clk_sys_in = 1'b0;
    logic nrst_in = 1'b0;
    logic sleep_in = 1'b0;
    logic gain_in = 1'b0;
    ddli_chan_in_t ch_a, ch_b;
    ddli_chan_out_t out_a, out_b, last_a, last_b;
    logic sleep_q, gain_q, upd_a, upd_b;
    int n_a = 0;
    int n_b = 0;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;

    ddli_host host_a (.clk_sys_in(clk_sys_in), .pins_out(ch_a));
    ddli_host host_b (.clk_sys_in(clk_sys_in), .pins_out(ch_b));
    ddli_top dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .ch_a_in(ch_a), .ch_b_in(ch_b),
        .sleep_control_in(sleep_in), .gain_resistor_select_in(gain_in),
        .ch_a_current_output_out(out_a), .ch_b_current_output_out(out_b),
        .sleep_active_out(sleep_q), .single_resistor_gain_out(gain_q),
        .ch_a_updated_out(upd_a), .ch_b_updated_out(upd_b));

    always #2.5 clk_sys_in = ~clk_sys_in;

    // ****************
    // monitors
    // ****************
    always @(posedge clk_sys_in)
    begin
        cycles++;
        if (upd_a === 1'b1)
        begin
            last_a = out_a;
            n_a++;
        end
        if (upd_b === 1'b1)
        begin
            last_b = out_b;
            n_b++;
        end
        if (cycles == 3000)
        begin
            mismatches++;
            wrap_up();
        end
    end

    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one write; the update shows the word forwarded by the previous one
    task automatic push(input bit on_b, input ddli_word_t w, input ddli_word_t prev);
        int a0, b0;
        a0 = n_a;
        b0 = n_b;
        if (on_b)
            host_b.send(w);
        else
            host_a.send(w);
        repeat (2) @(posedge clk_sys_in);
        chk(20'(n_a - a0), {19'h0, !on_b});
        chk(20'(n_b - b0), {19'h0, on_b});
        chk(on_b ? last_b : last_a, {prev, ~prev});
    endtask : push

    // ****************
    // scenarios
    // ****************
    task automatic t_pipeline;
        push(1'b0, 10'h3ff, 10'h000);
        push(1'b0, 10'h000, 10'h3ff);
        push(1'b0, 10'h200, 10'h000);
        push(1'b0, 10'h155, 10'h200);
        $display("test pipeline done");
    endtask : t_pipeline

    task automatic t_indep;
        push(1'b1, 10'h2aa, 10'h000);
        push(1'b1, 10'h0d5, 10'h2aa);
        chk(out_a, {10'h200, 10'h1ff});
        $display("test independence done");
    endtask : t_indep

    task automatic t_modes;
        @(posedge clk_sys_in);
        sleep_in <= 1'b1;
        gain_in <= 1'b1;
        repeat (6) @(posedge clk_sys_in);
        chk({sleep_q, gain_q}, 20'h3);
        chk(out_a | out_b, 20'h0);
        sleep_in <= 1'b0;
        gain_in <= 1'b0;
        repeat (6) @(posedge clk_sys_in);
        chk({sleep_q, gain_q}, 20'h0);
        chk(out_b, {10'h2aa, 10'h155});
        $display("test modes done");
    endtask : t_modes

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    initial
    begin
        repeat (6) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        t_pipeline();
        t_indep();
        t_modes();
        wrap_up();
    end
endmodule : ddli_top_bench

// ---- verilog/ddli_channel.sv ----
// one converter channel: input latch, forward stage and converter latch
`timescale 1ns/100ps
`include "ddli_consts.svh"
module ddli_channel
#(
    parameter int WIDTH = `DDLI_SAMPLE_W
)
(
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic strobe_in,
    input wire logic update_in,
    input wire logic [WIDTH-1:0] word_in,
    output logic [WIDTH-1:0] conv_out,
    output logic update_rise_out
);
    // ***********************************************
    // pin synchronisers
    // ***********************************************
    logic [1:0] strobe_sync_ff;
    logic [1:0] update_sync_ff;
    logic strobe_dly_ff;
    logic update_dly_ff;
    logic [WIDTH-1:0] word_s1_ff;
    logic [WIDTH-1:0] word_s2_ff;
    logic [WIDTH-1:0] input_latch_ff;
    logic [WIDTH-1:0] fwd_ff;
    logic [WIDTH-1:0] conv_ff;
    wire strobe_rise = strobe_sync_ff[1] & ~strobe_dly_ff;
    wire strobe_fall = ~strobe_sync_ff[1] & strobe_dly_ff;
    wire update_rise = update_sync_ff[1] & ~update_dly_ff;
    // two word stages line up with the second strobe stage, so a tied
    // strobe captures the word that stood at its own pin edge
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            strobe_sync_ff <= 2'h0;
            update_sync_ff <= 2'h0;
            strobe_dly_ff <= 1'b0;
            update_dly_ff <= 1'b0;
            word_s1_ff <= '0;
            word_s2_ff <= '0;
        end
        else
        begin
            strobe_sync_ff <= {strobe_sync_ff[0], strobe_in};
            update_sync_ff <= {update_sync_ff[0], update_in};
            strobe_dly_ff <= strobe_sync_ff[1];
            update_dly_ff <= update_sync_ff[1];
            word_s1_ff <= word_in;
            word_s2_ff <= word_s1_ff;
        end
    end
    // ***********************************************
    // double latch
    // ***********************************************
    // a strobe tied to the update clock forwards on the fall, so the
    // converter takes that word on the following rising edge
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            input_latch_ff <= '0;
            fwd_ff <= '0;
            conv_ff <= '0;
            update_rise_out <= 1'b0;
        end
        else
        begin
            if (strobe_rise)
                input_latch_ff <= word_s2_ff;
            if (strobe_fall)
                fwd_ff <= input_latch_ff;
            if (update_rise)
                conv_ff <= fwd_ff;
            update_rise_out <= update_rise;
        end
    end
    assign conv_out = conv_ff;
    generate
        if (WIDTH < 1)
        begin : g_bad_width
            $error("ddli_channel: width must be positive");
        end
    endgenerate
    chk_conv_hold: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        !update_rise |=> $stable(conv_ff)) else $error("converter latch moved");
    chk_conv_load: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        update_rise |=> conv_ff == $past(fwd_ff)) else $error("converter load wrong");
    chk_fwd_load: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        strobe_fall |=> fwd_ff == $past(input_latch_ff)) else $error("forward wrong");
    chk_fwd_hold: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        !strobe_fall |=> $stable(fwd_ff)) else $error("forward moved");
    chk_input_load: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        strobe_rise |=> input_latch_ff == $past(word_s2_ff)) else $error("capture wrong");
    chk_input_hold: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        !strobe_rise |=> $stable(input_latch_ff)) else $error("input moved");
endmodule : ddli_channel

// ---- verilog/ddli_consts.svh ----
// constants for the dual converter double-latch input block
`ifndef DDLI_CONSTS_SVH
`define DDLI_CONSTS_SVH
`define DDLI_SAMPLE_W 10
`define DDLI_SAMPLE_MSB 9
`define DDLI_WORD_ZERO 10'h000
`define DDLI_WORD_ONES 10'h3ff
`define DDLI_MAX_RATE_MSPS 125
`define DDLI_SYS_CLK_MHZ 200
`endif

// ---- verilog/ddli_pkg.sv ----
// types for the dual converter double-latch input block
`include "ddli_consts.svh"
package ddli_pkg;
    typedef logic [`DDLI_SAMPLE_MSB:0] ddli_word_t;
    // one channel's host-side pins
    typedef struct packed {
        logic input_strobe;
        logic update_clock;
        ddli_word_t word;
    } ddli_chan_in_t;
    // one channel's drive to the current switches
    typedef struct packed {
        ddli_word_t true_steer;
        ddli_word_t comp_steer;
    } ddli_chan_out_t;
endpackage : ddli_pkg

// ---- verilog/ddli_top.sv ----
// top of the dual converter double-latch input block
`timescale 1ns/100ps
`include "ddli_consts.svh"
// Operation
// - words are straight binary, bit nine MSB
// - two independent ten-bit sample channels
// - each channel has own strobe and clock
// - strobe rise captures port into input latch
// - strobe fall forwards input latch word
// - update clock rise loads converter latch
// - sleep high powers down both channels
// - gain select high one resistor mode
// - ones drive true, zeros complementary output
module ddli_top
(
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input ddli_pkg::ddli_chan_in_t ch_a_in,
    input ddli_pkg::ddli_chan_in_t ch_b_in,
    input wire logic sleep_control_in,
    input wire logic gain_resistor_select_in,
    output ddli_pkg::ddli_chan_out_t ch_a_current_output_out,
    output ddli_pkg::ddli_chan_out_t ch_b_current_output_out,
    output logic sleep_active_out,
    output logic single_resistor_gain_out,
    output logic ch_a_updated_out,
    output logic ch_b_updated_out
);
    import ddli_pkg::*;
    // ***********************************************
    // channels
    // ***********************************************
    // fully separate instances keep one channel's strobe off the other
    ddli_word_t conv_a;
    ddli_word_t conv_b;
    logic rise_a;
    logic rise_b;
    ddli_channel #(.WIDTH(`DDLI_SAMPLE_W)) u_ch_a
    (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .strobe_in(ch_a_in.input_strobe),
        .update_in(ch_a_in.update_clock),
        .word_in(ch_a_in.word),
        .conv_out(conv_a),
        .update_rise_out(rise_a)
    );
    ddli_channel #(.WIDTH(`DDLI_SAMPLE_W)) u_ch_b
    (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .strobe_in(ch_b_in.input_strobe),
        .update_in(ch_b_in.update_clock),
        .word_in(ch_b_in.word),
        .conv_out(conv_b),
        .update_rise_out(rise_b)
    );
    // ***********************************************
    // control pins
    // ***********************************************
    logic [1:0] sleep_sync_ff;
    logic [1:0] gain_sync_ff;
    // sleep resets low: an undriven pin means normal operation
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            sleep_sync_ff <= 2'h0;
        end
        else
        begin
            sleep_sync_ff <= {sleep_sync_ff[0], sleep_control_in};
        end
    end
    // gain mode is a static strap, two flops are plenty
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            gain_sync_ff <= 2'h0;
        end
        else
        begin
            gain_sync_ff <= {gain_sync_ff[0], gain_resistor_select_in};
        end
    end
    wire sleep_now = sleep_sync_ff[1];
    wire gain_now = gain_sync_ff[1];
    // ***********************************************
    // output steering
    // ***********************************************
    // straight binary: bit weights go to the true side as is, the
    // complement to the other side; sleep parks both at zero current
    function automatic ddli_chan_out_t steer(input ddli_word_t w, input logic off);
        ddli_chan_out_t r;
        r.true_steer = off ? `DDLI_WORD_ZERO : w;
        r.comp_steer = off ? `DDLI_WORD_ZERO : ~w;
        return r;
    endfunction : steer
    wire ddli_chan_out_t nxt_a = steer(conv_a, sleep_now);
    wire ddli_chan_out_t nxt_b = steer(conv_b, sleep_now);
    // one output block per channel keeps each side's switches apart
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            ch_a_current_output_out <= '0;
            ch_a_updated_out <= 1'b0;
        end
        else
        begin
            ch_a_current_output_out <= nxt_a;
            ch_a_updated_out <= rise_a;
        end
    end
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            ch_b_current_output_out <= '0;
            ch_b_updated_out <= 1'b0;
        end
        else
        begin
            ch_b_current_output_out <= nxt_b;
            ch_b_updated_out <= rise_b;
        end
    end
    // ***********************************************
    // status
    // ***********************************************
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            sleep_active_out <= 1'b0;
            single_resistor_gain_out <= 1'b0;
        end
        else
        begin
            sleep_active_out <= sleep_now;
            single_resistor_gain_out <= gain_now;
        end
    end
    // ***********************************************
    // checks
    // ***********************************************
    chk_sleep_zero: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        sleep_sync_ff[1] |=> ch_a_current_output_out == '0 && ch_b_current_output_out == '0)
        else $error("sleep left current on");
    chk_comp_pair: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        !sleep_sync_ff[1] |=> ch_a_current_output_out.comp_steer
        == ~ch_a_current_output_out.true_steer) else $error("outputs not complementary");
    chk_true_word: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        !sleep_sync_ff[1] |=> ch_b_current_output_out.true_steer == $past(conv_b))
        else $error("true output wrong");
    chk_gain_follow: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        1'b1 |=> single_resistor_gain_out == $past(gain_sync_ff[1]))
        else $error("gain mode wrong");
    chk_sleep_follow: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        1'b1 |=> sleep_active_out == $past(sleep_now))
        else $error("sleep status wrong");
    chk_sleep_status_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        sleep_active_out |-> ch_a_current_output_out == '0)
        else $error("channel a on in sleep");
    chk_sleep_status_b: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        sleep_active_out |-> ch_b_current_output_out == '0)
        else $error("channel b on in sleep");
    chk_comp_pair_b: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        !sleep_now |=> ch_b_current_output_out.comp_steer == ~ch_b_current_output_out.true_steer)
        else $error("channel b not complementary");
    chk_true_word_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        !sleep_now |=> ch_a_current_output_out.true_steer == $past(conv_a))
        else $error("channel a true output wrong");
    // scale ends: all ones puts all ones on a's true side, all zeros puts all ones on b's complementary side
    chk_ones_full_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        !sleep_now && conv_a == `DDLI_WORD_ONES |=>
        ch_a_current_output_out.true_steer == `DDLI_WORD_ONES
        && ch_a_current_output_out.comp_steer == `DDLI_WORD_ZERO)
        else $error("channel a full scale wrong");
    chk_zero_full_b: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        !sleep_now && conv_b == `DDLI_WORD_ZERO |=>
        ch_b_current_output_out.comp_steer == `DDLI_WORD_ONES
        && ch_b_current_output_out.true_steer == `DDLI_WORD_ZERO)
        else $error("channel b zero scale wrong");
    // update pulses: one per edge seen, never two in a row
    chk_upd_a_pulse: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        1'b1 |=> ch_a_updated_out == $past(rise_a))
        else $error("channel a update pulse wrong");
    chk_upd_b_pulse: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        1'b1 |=> ch_b_updated_out == $past(rise_b))
        else $error("channel b update pulse wrong");
    chk_upd_a_single: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        ch_a_updated_out |=> !ch_a_updated_out)
        else $error("channel a pulse too long");
    chk_upd_b_single: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        ch_b_updated_out |=> !ch_b_updated_out)
        else $error("channel b pulse too long");
endmodule : ddli_top
